// ==== hdl/tcls_pkg.sv ====
// package: constants and types of the turn counter and lock status block
package tcls_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CORE_CLK_MHZ   = 200;
    localparam int unsigned TRACK_STEP_NS  = 1150;
    localparam int unsigned TRACK_STEP_CYC =
        (TRACK_STEP_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int unsigned PWM_FREQ_HZ    = 1950;
    localparam int unsigned PWM_PERIOD_CYC =
        (CORE_CLK_MHZ * 1000000) / PWM_FREQ_HZ;
    localparam int unsigned PWM_STEP_NS    = 2000;
    localparam int unsigned PWM_STEP_CYC   =
        (PWM_STEP_NS * CORE_CLK_MHZ) / 1000;
    localparam int unsigned TICK_W         = 8;
    localparam int unsigned PWM_CNT_W      = 17;

    // ------------------------------------------------------------------
    // widths and values
    // ------------------------------------------------------------------
    localparam int unsigned ANGLE_W = 8;
    localparam int unsigned TURNS_W = 8;
    localparam int unsigned AGC_W   = 6;
    localparam int unsigned SENS_W  = 3;
    localparam int unsigned CMD_W   = 5;
    localparam int unsigned DATA_W  = 16;
    localparam int unsigned BITS_W  = 5;

    localparam logic [TURNS_W-1:0] TURNS_RESET = 8'h00;
    localparam logic [ANGLE_W-1:0] ANGLE_TOP   = 8'hFF;
    localparam logic [ANGLE_W-1:0] ANGLE_ZERO  = 8'h00;
    localparam logic [ANGLE_W-1:0] ANGLE_ONE   = 8'h01;
    localparam logic [AGC_W-1:0]   AGC_MAX     = 6'h3F;
    localparam logic [AGC_W-1:0]   AGC_MIN     = 6'h00;
    localparam logic [AGC_W-1:0]   AGC_RESET   = 6'h20;

    // ------------------------------------------------------------------
    // serial commands and frame layout
    // ------------------------------------------------------------------
    localparam logic [CMD_W-1:0]  CMD_RD_ANGLE    = 5'h10;
    localparam logic [CMD_W-1:0]  CMD_RD_TURNS    = 5'h11;
    localparam logic [CMD_W-1:0]  CMD_RD_BOTH     = 5'h12;
    localparam logic [CMD_W-1:0]  CMD_CLEAR_TURNS = 5'h13;
    localparam logic [BITS_W-1:0] CMD_LAST_BIT    = 5'h04;
    localparam logic [BITS_W-1:0] FRAME_LAST_BIT  = 5'h14;

    // ------------------------------------------------------------------
    // status bundle handed to the serial link
    // ------------------------------------------------------------------
    typedef struct packed {
        logic               lock;
        logic [AGC_W-1:0]   agc;
        logic [ANGLE_W-1:0] angle;
        logic [TURNS_W-1:0] turns;
    } tcls_snap_s;

endpackage

// ==== hdl/tcls_top.sv ====
// design: turn counter, tracking lock, gain status, pwm and serial readout
module tcls_top (
    // clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire logic                          clk_en,
    // front end
    input  wire logic [tcls_pkg::ANGLE_W-1:0]  angle_meas,
    input  wire logic                          field_low,
    input  wire logic                          field_high,
    input  wire logic                          low_power,
    input  wire logic [tcls_pkg::SENS_W-1:0]   sens_cfg,
    // serial link
    input  wire logic                          ssi_clk,
    input  wire logic                          ssi_cs,
    input  wire logic                          ssi_din,
    output logic                               ssi_dout,
    // status
    output logic [tcls_pkg::SENS_W-1:0]        sens_gain,
    output logic [tcls_pkg::ANGLE_W-1:0]       track_angle,
    output logic                               lock,
    output logic [tcls_pkg::AGC_W-1:0]         agc,
    output logic [tcls_pkg::TURNS_W-1:0]       turn_count,
    output logic                               field_weak_out,
    output logic                               pwm_out
);
    import tcls_pkg::*;

    localparam logic [TICK_W-1:0]    TICK_LAST  = TICK_W'(TRACK_STEP_CYC - 1);
    localparam logic [PWM_CNT_W-1:0] PWM_LAST   = PWM_CNT_W'(PWM_PERIOD_CYC-1);
    localparam logic [PWM_CNT_W-1:0] PWM_STEP   = PWM_CNT_W'(PWM_STEP_CYC);
    localparam logic [PWM_CNT_W-1:0] PWM_ONE    = 17'h00001;

    // ------------------------------------------------------------------
    // core domain state
    // ------------------------------------------------------------------
    logic [TICK_W-1:0]    tick_cnt_ff;
    logic [ANGLE_W-1:0]   pos_ff;
    logic                 lock_ff;
    logic [AGC_W-1:0]     agc_ff;
    logic [SENS_W-1:0]    gain_ff;
    logic [TURNS_W-1:0]   turns_ff;
    logic [TURNS_W-1:0]   nxt_turns;
    logic                 weak_ff;
    logic [PWM_CNT_W-1:0] pwm_cnt_ff;
    logic [PWM_CNT_W-1:0] pwm_width_ff;
    logic                 pwm_ff;
    logic                 clr_s1_ff;
    logic                 clr_s2_ff;
    logic                 clr_s3_ff;
    logic                 ack_s1_ff;
    logic                 ack_s2_ff;
    logic                 req_tgl_ff;
    tcls_snap_s           hold_ff;

    logic                 tick;
    logic [ANGLE_W-1:0]   diff;
    logic                 step;
    logic                 step_dn;
    logic                 wrap_up;
    logic                 wrap_dn;
    logic                 clr_pulse;

    // ------------------------------------------------------------------
    // link domain state
    // ------------------------------------------------------------------
    logic                 link_rst;
    logic [BITS_W-1:0]    bit_cnt_ff;
    logic [CMD_W-1:0]     cmd_ff;
    logic [DATA_W-1:0]    shift_ff;
    logic                 dout_ff;
    logic                 clr_tgl_ff;
    logic                 req_s1_ff;
    logic                 req_s2_ff;
    logic                 ack_tgl_ff;
    tcls_snap_s           cap_ff;
    logic [CMD_W-1:0]     cmd_full;

    // ------------------------------------------------------------------
    // tracking converter
    // ------------------------------------------------------------------
    assign tick     = clk_en && (tick_cnt_ff == TICK_LAST);
    assign diff     = angle_meas - pos_ff;
    // shortest way round: top bit of the difference gives the direction
    assign step_dn  = diff[ANGLE_W-1];
    assign step     = tick && !low_power && (diff != ANGLE_ZERO);
    assign wrap_up  = step && !step_dn && (pos_ff == ANGLE_TOP);
    assign wrap_dn  = step && step_dn && (pos_ff == ANGLE_ZERO);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_ff <= '0;
        end else if (clk_en) begin
            tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pos_ff <= ANGLE_ZERO;
        end else if (step) begin
            // one code per tick, also when resuming from low power
            pos_ff <= step_dn ? pos_ff - ANGLE_ONE
                              : pos_ff + ANGLE_ONE;
        end
    end

    // lock kept while the angle stays within one code per tick, which
    // covers full speed since a code lasts several microseconds there
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lock_ff <= 1'b0;
        end else if (tick && !low_power) begin
            lock_ff <= (diff == ANGLE_ZERO) ||
                       (lock_ff && (diff == ANGLE_ONE ||
                                    diff == ANGLE_TOP));
        end
    end

    // ------------------------------------------------------------------
    // gain control and weak field pin
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            agc_ff <= AGC_RESET;
        end else if (tick && !low_power) begin
            if (field_low && agc_ff != AGC_MAX) begin
                agc_ff <= agc_ff + 1'b1;
            end else if (field_high && agc_ff != AGC_MIN) begin
                agc_ff <= agc_ff - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            weak_ff <= 1'b1;
            gain_ff <= '0;
        end else if (clk_en) begin
            weak_ff <= (agc_ff != AGC_MAX);
            gain_ff <= sens_cfg;
        end
    end

    // ------------------------------------------------------------------
    // turn counter
    // ------------------------------------------------------------------
    assign clr_pulse = clr_s2_ff ^ clr_s3_ff;

    always_comb begin
        // clear first, so a crossing in the same cycle still counts
        nxt_turns = clr_pulse ? TURNS_RESET : turns_ff;
        if (wrap_up) begin
            nxt_turns = nxt_turns + 1'b1;
        end else if (wrap_dn) begin
            nxt_turns = nxt_turns - 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            turns_ff <= TURNS_RESET;
        end else if (clk_en) begin
            turns_ff <= nxt_turns;
        end
    end

    // ------------------------------------------------------------------
    // pwm angle output
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwm_cnt_ff   <= '0;
            pwm_width_ff <= PWM_STEP;
            pwm_ff       <= 1'b0;
        end else if (clk_en) begin
            if (pwm_cnt_ff == PWM_LAST) begin
                pwm_cnt_ff   <= '0;
                pwm_width_ff <= PWM_CNT_W'(({9'h000, pos_ff} + PWM_ONE)
                                           * PWM_STEP);
            end else begin
                pwm_cnt_ff <= pwm_cnt_ff + 1'b1;
            end
            pwm_ff <= (pwm_cnt_ff < pwm_width_ff);
        end
    end

    // ------------------------------------------------------------------
    // crossings: status words by toggle handshake, clear by toggle
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clr_s1_ff  <= 1'b0;
            clr_s2_ff  <= 1'b0;
            clr_s3_ff  <= 1'b0;
            ack_s1_ff  <= 1'b0;
            ack_s2_ff  <= 1'b0;
            req_tgl_ff <= 1'b0;
            hold_ff    <= '0;
        end else if (clk_en) begin
            clr_s1_ff <= clr_tgl_ff;
            clr_s2_ff <= clr_s1_ff;
            clr_s3_ff <= clr_s2_ff;
            ack_s1_ff <= ack_tgl_ff;
            ack_s2_ff <= ack_s1_ff;
            // hold stays still while the link side may sample it
            if (ack_s2_ff == req_tgl_ff) begin
                hold_ff    <= '{lock: lock_ff, agc: agc_ff,
                                angle: pos_ff, turns: nxt_turns};
                req_tgl_ff <= ~req_tgl_ff;
            end
        end
    end

    // ------------------------------------------------------------------
    // serial link, on the host's clock
    // ------------------------------------------------------------------
    // the link clock stops between frames, so select low ends the frame
    assign link_rst = rst | ~ssi_cs;
    assign cmd_full = {cmd_ff[CMD_W-2:0], ssi_din};

    function automatic logic [DATA_W-1:0] answer(
        input logic [CMD_W-1:0] cmd,
        input tcls_snap_s       s
    );
        logic [DATA_W-2:0] body;
        body   = '0;
        answer = '0;
        unique case (cmd)
            CMD_RD_ANGLE: begin
                body   = {s.lock, 1'b0, s.agc, s.angle[ANGLE_W-1:1]};
                answer = {body[DATA_W-2], ^body,
                          body[DATA_W-3:0]};
            end
            CMD_RD_TURNS: begin
                body   = {s.lock, s.agc, s.turns};
                answer = {body[DATA_W-2], ^body,
                          body[DATA_W-3:0]};
            end
            CMD_RD_BOTH: begin
                answer = {s.angle, s.turns};
            end
            default: begin
                answer = '0;
            end
        endcase
    endfunction

    always_ff @(posedge ssi_clk or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_ff <= '0;
            cmd_ff     <= '0;
            shift_ff   <= '0;
            dout_ff    <= 1'b0;
        end else if (bit_cnt_ff <= FRAME_LAST_BIT) begin
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
            if (bit_cnt_ff < CMD_LAST_BIT) begin
                cmd_ff <= cmd_full;
            end else if (bit_cnt_ff == CMD_LAST_BIT) begin
                cmd_ff   <= cmd_full;
                shift_ff <= answer(cmd_full, cap_ff);
            end else begin
                dout_ff  <= shift_ff[DATA_W-1];
                shift_ff <= {shift_ff[DATA_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ssi_clk or posedge rst) begin
        if (rst) begin
            clr_tgl_ff <= 1'b0;
            req_s1_ff  <= 1'b0;
            req_s2_ff  <= 1'b0;
            ack_tgl_ff <= 1'b0;
            cap_ff     <= '0;
        end else if (ssi_cs) begin
            if (bit_cnt_ff == CMD_LAST_BIT &&
                cmd_full == CMD_CLEAR_TURNS) begin
                clr_tgl_ff <= ~clr_tgl_ff;
            end
            req_s1_ff <= req_tgl_ff;
            req_s2_ff <= req_s1_ff;
            if (req_s2_ff != ack_tgl_ff) begin
                cap_ff     <= hold_ff;
                ack_tgl_ff <= req_s2_ff;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign ssi_dout       = dout_ff;
    assign sens_gain      = gain_ff;
    assign track_angle    = pos_ff;
    assign lock           = lock_ff;
    assign agc            = agc_ff;
    assign turn_count     = turns_ff;
    assign field_weak_out = weak_ff;
    assign pwm_out        = pwm_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_wrap_up;
        @(posedge core_clk) disable iff (rst)
        clk_en && wrap_up && !clr_pulse |=>
            turns_ff == $past(turns_ff) + 8'h01;
    endproperty
    a_wrap_up: assert property (p_wrap_up)
        else $error("count did not rise on forward wrap");

    property p_wrap_dn;
        @(posedge core_clk) disable iff (rst)
        clk_en && wrap_dn && !clr_pulse |=>
            turns_ff == $past(turns_ff) - 8'h01;
    endproperty
    a_wrap_dn: assert property (p_wrap_dn)
        else $error("count did not fall on backward wrap");

    property p_clear;
        @(posedge core_clk) disable iff (rst)
        clk_en && clr_pulse && !wrap_up && !wrap_dn |=> turns_ff == 8'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("count not zero after clear");

    property p_clear_toggle;
        @(posedge ssi_clk) disable iff (rst)
        ssi_cs && bit_cnt_ff == CMD_LAST_BIT && cmd_full == CMD_CLEAR_TURNS
            |=> clr_tgl_ff != $past(clr_tgl_ff);
    endproperty
    a_clear_toggle: assert property (p_clear_toggle)
        else $error("clear command not forwarded at its last bit");

    property p_weak_pin;
        @(posedge core_clk) disable iff (rst)
        clk_en && agc_ff == AGC_MAX |=> !field_weak_out;
    endproperty
    a_weak_pin: assert property (p_weak_pin)
        else $error("weak field pin high at gain ceiling");

    property p_track_gap;
        @(posedge core_clk) disable iff (rst)
        tick |=> !tick [*8];
    endproperty
    a_track_gap: assert property (p_track_gap)
        else $error("tracking steps too close together");

    property p_lock_rise;
        @(posedge core_clk) disable iff (rst)
        $rose(lock_ff) |-> $past(tick && diff == 8'h00);
    endproperty
    a_lock_rise: assert property (p_lock_rise)
        else $error("lock set without matching angle");

    property p_freeze;
        @(posedge core_clk) disable iff (rst)
        low_power ##1 low_power |-> $stable(pos_ff) && $stable(lock_ff);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("tracking moved in low power");

    property p_single_step;
        @(posedge core_clk) disable iff (rst)
        step |=> (pos_ff - $past(pos_ff) == 8'h01) ||
                 ($past(pos_ff) - pos_ff == 8'h01);
    endproperty
    a_single_step: assert property (p_single_step)
        else $error("tracking moved by more than one code");

    property p_pwm_start;
        @(posedge core_clk) disable iff (rst)
        clk_en && pwm_cnt_ff == 17'h00001 |=> pwm_out;
    endproperty
    a_pwm_start: assert property (p_pwm_start)
        else $error("pwm low at period start");

endmodule

// ==== verif/tcls_host.sv ====
// host model: drives serial frames and collects the answer bits
module tcls_host (
    // serial link
    output logic      ssi_clk,
    output logic      ssi_cs,
    output logic      ssi_din,
    input  wire logic ssi_dout
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        ssi_clk = 1'b0;
        ssi_cs  = 1'b0;
        ssi_din = 1'b1;
    end

    // ----------------------------------------
    // one frame
    // ----------------------------------------
    // clock stands still between frames; din toggles on every unused bit
    task automatic frame(input logic [4:0] cmd, output logic [15:0] ans);
        int k;
        ans = 16'h0000;
        ssi_cs = 1'b1;
        for (k = 1; k <= 21; k++) begin
            if (k <= 5) ssi_din = cmd[5-k];
            else ssi_din = ~ssi_din;
            #3 ssi_clk = 1'b1;
            #3 ssi_clk = 1'b0;
            if (k >= 6) ans[21-k] = ssi_dout;
        end
        #3 ssi_cs = 1'b0;
        #6;
    endtask
endmodule

// ==== verif/tb_turn_counter_lock_status.sv ====
// testbench: tracking, turn count, gain, pwm and serial readout
module tb_turn_counter_lock_status;
    timeunit 1ns;
    timeprecision 100ps;
    import tcls_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic                core_clk    = 1'b0;
    logic                rst         = 1'b1;
    logic [ANGLE_W-1:0]  angle_meas  = 8'h00;
    logic                field_low   = 1'b0;
    logic                field_high  = 1'b0;
    logic                low_power   = 1'b0;
    logic [SENS_W-1:0]   sens_cfg    = 3'h0;
    logic                ssi_clk;
    logic                ssi_cs;
    logic                ssi_din;
    logic                ssi_dout;
    logic [SENS_W-1:0]   sens_gain;
    logic [ANGLE_W-1:0]  track_angle;
    logic                lock;
    logic [AGC_W-1:0]    agc;
    logic [TURNS_W-1:0]  turn_count;
    logic                field_weak_out;
    logic                pwm_out;
    logic [15:0]         ans;
    int                  errors      = 0;
    int                  checks_done = 0;
    int                  n;

    always #2.5 core_clk = ~core_clk;

    tcls_top u_dut (
        .core_clk(core_clk), .rst(rst), .clk_en(1'b1),
        .angle_meas(angle_meas), .field_low(field_low),
        .field_high(field_high), .low_power(low_power),
        .sens_cfg(sens_cfg), .ssi_clk(ssi_clk), .ssi_cs(ssi_cs),
        .ssi_din(ssi_din), .ssi_dout(ssi_dout), .sens_gain(sens_gain),
        .track_angle(track_angle), .lock(lock), .agc(agc),
        .turn_count(turn_count), .field_weak_out(field_weak_out),
        .pwm_out(pwm_out)
    );

    tcls_host u_host (
        .ssi_clk(ssi_clk), .ssi_cs(ssi_cs),
        .ssi_din(ssi_din), .ssi_dout(ssi_dout)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic cyc(input int k);
        repeat (k) begin
            @(posedge core_clk);
            #1;
        end
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    // bounded: a stuck tracker shows up as a failed compare afterwards
    task automatic wait_pos(input logic [7:0] pos);
        for (n = 0; n < 3000 && track_angle !== pos; n++) cyc(1);
    endtask

    // snapshot may lag a few frames, so the last of three counts
    task automatic rd(input logic [4:0] c);
        repeat (3) u_host.frame(c, ans);
    endtask

    task automatic finish_test();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        #300000;
        errors++;
        finish_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        cyc(20);
        @(posedge core_clk);
        rst      <= 1'b0;
        sens_cfg <= 3'h5;
        cyc(1);
        check(16'(turn_count), 16'h0000, "count after reset");
        check(16'(agc), 16'h0020, "gain after reset");
        check(16'(field_weak_out), 16'h0001, "weak pin");
        cyc(100);
        check(16'(pwm_out), 16'h0001, "pwm early");
        check(16'(sens_gain), 16'h0005, "sensitivity");
        cyc(140);
        check(16'(lock), 16'h0001, "lock at start");
        cyc(360);
        check(16'(pwm_out), 16'h0000, "pwm late");
        @(posedge core_clk);
        angle_meas <= 8'hFE;
        wait_pos(8'hFF);
        check(16'(turn_count), 16'h00FF, "down wrap");
        check(16'(lock), 16'h0000, "unlocked");
        wait_pos(8'hFE);
        cyc(232);
        check(16'(lock), 16'h0001, "relocked");
        check(16'(lock && agc > AGC_MIN && agc < 6'h2F), 16'h0001,
              "trusted angle");
        rd(CMD_RD_TURNS);
        check(ans, {2'b10, 6'h20, 8'hFF}, "turns read");
        rd(CMD_RD_ANGLE);
        check(ans, {2'b11, 1'b0, 6'h20, 7'h7F}, "angle read");
        rd(CMD_RD_BOTH);
        check(ans, 16'hFEFF, "both read");
        u_host.frame(CMD_CLEAR_TURNS, ans);
        cyc(10);
        check(16'(turn_count), 16'h0000, "cleared");
        check(ans, 16'h0000, "clear answer");
        @(posedge core_clk);
        angle_meas <= 8'h01;
        wait_pos(8'h00);
        check(16'(turn_count), 16'h0001, "up wrap");
        wait_pos(8'h01);
        @(posedge core_clk);
        low_power  <= 1'b1;
        angle_meas <= 8'h05;
        cyc(700);
        check(16'(track_angle), 16'h0001, "frozen");
        @(posedge core_clk);
        low_power <= 1'b0;
        wait_pos(8'h05);
        check(16'(track_angle), 16'h0005, "resumed");
        @(posedge core_clk);
        field_low <= 1'b1;
        for (n = 0; n < 9000 && agc !== AGC_MAX; n++) cyc(1);
        cyc(2);
        check(16'(agc), 16'h003F, "gain up");
        check(16'(field_weak_out), 16'h0000, "weak low");
        @(posedge core_clk);
        field_low  <= 1'b0;
        field_high <= 1'b1;
        for (n = 0; n < 300 && agc === AGC_MAX; n++) cyc(1);
        @(posedge core_clk);
        field_high <= 1'b0;
        cyc(2);
        check(16'(agc), 16'h003E, "gain down");
        check(16'(field_weak_out), 16'h0001, "weak high");
        finish_test();
    end
endmodule
